// >>> dma_irq_pkg.sv
// shared constants for the dma interrupt request logic
package dma_irq_pkg;
  localparam int NUM_USER_IRQ = 16;
  localparam int MAX_VECTORS = 32;
  localparam int VEC_W = 5;
  localparam int DESC_CNT_W = 16;
  localparam int ADDR_W = 64;
  // byte step between adjacent descriptors
  localparam int DESC_STRIDE = 32;
  // legacy line codes
  localparam logic [1:0] LEG_LINE_A = 2'h0;
  localparam logic [1:0] LEG_LINE_B = 2'h1;
  localparam logic [1:0] LEG_LINE_C = 2'h2;
  localparam logic [1:0] LEG_LINE_D = 2'h3;
  // signalling modes
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_MSI = 2'h1;
  localparam logic [1:0] MODE_MSIX = 2'h2;
  // reset source select
  localparam logic [1:0] RST_SRC_USER = 2'h0;
  localparam logic [1:0] RST_SRC_SYS = 2'h1;
  localparam logic [1:0] RST_SRC_PHY = 2'h2;
  localparam logic [1:0] RST_SRC_RESET = 2'h0;
  // engine indices
  localparam int ENG_HOST_TO_CARD_IDX = 0;
  localparam int ENG_CARD_TO_HOST_IDX = 1;
  localparam int NUM_ENG = 2;
  // error codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_FETCH = 2'h1;
  localparam logic [1:0] ERR_DATA = 2'h2;
endpackage

// >>> dma_engine_seq.sv
// one transfer engine: descriptor fetch, data move, completion status
`timescale 1ns/1ps
module dma_engine_seq #(
  parameter int CNT_W = dma_irq_pkg::DESC_CNT_W,
  parameter int AW = dma_irq_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic dma_rstn,
  input wire logic run,
  input wire logic [AW-1:0] desc_start_addr,
  input wire logic [CNT_W-1:0] desc_adjacent,
  output logic desc_fetch_req,
  output logic [AW-1:0] desc_fetch_addr,
  input wire logic desc_fetch_ack,
  input wire logic desc_fetch_err,
  output logic data_move_req,
  input wire logic data_move_done,
  input wire logic data_move_err,
  output logic busy,
  output logic done_pulse,
  output logic [1:0] err_code,
  output logic [CNT_W-1:0] desc_completed
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_MOVE = 4'b0100,
    ST_DONE = 4'b1000
  } eng_state_t;

  eng_state_t state_q;
  logic [CNT_W-1:0] left_q;
  logic [AW-1:0] addr_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] err_q;
  logic done_q;

  // fetch each descriptor, then move its data, in turn
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      state_q <= ST_IDLE;
      left_q <= '0;
      addr_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (run) begin
            state_q <= ST_FETCH;
            left_q <= desc_adjacent;
            addr_q <= desc_start_addr;
          end
        end
        ST_FETCH: begin
          if (desc_fetch_err) begin
            state_q <= ST_DONE;
          end else if (desc_fetch_ack) begin
            state_q <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (data_move_err) begin
            state_q <= ST_DONE;
          end else if (data_move_done) begin
            if (left_q == '0) begin
              state_q <= ST_DONE;
            end else begin
              left_q <= left_q - 1'b1;
              addr_q <= addr_q + AW'(dma_irq_pkg::DESC_STRIDE);
              state_q <= ST_FETCH;
            end
          end
        end
        ST_DONE: begin
          if (!run) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // completed count and error status
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      cnt_q <= '0;
      err_q <= dma_irq_pkg::ERR_NONE;
    end else if (state_q == ST_IDLE && run) begin
      cnt_q <= '0;
      err_q <= dma_irq_pkg::ERR_NONE;
    end else if (state_q == ST_FETCH && desc_fetch_err) begin
      err_q <= dma_irq_pkg::ERR_FETCH;
    end else if (state_q == ST_MOVE && data_move_err) begin
      err_q <= dma_irq_pkg::ERR_DATA;
    end else if (state_q == ST_MOVE && data_move_done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // completion pulse when chain ends
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_MOVE) && (data_move_err || (data_move_done && left_q == '0))
        || (state_q == ST_FETCH && desc_fetch_err);
    end
  end

  assign desc_fetch_req = (state_q == ST_FETCH);
  assign desc_fetch_addr = addr_q;
  assign data_move_req = (state_q == ST_MOVE);
  assign busy = (state_q == ST_FETCH) || (state_q == ST_MOVE);
  assign done_pulse = done_q;
  assign err_code = err_q;
  assign desc_completed = cnt_q;
endmodule

// >>> dma_irq_request_logic.sv
// interrupt signalling, completion status and reset selection of the dma
`timescale 1ns/1ps
module dma_irq_request_logic #(
  parameter int NUM_USR = dma_irq_pkg::NUM_USER_IRQ,
  parameter int MSI_VECTORS = dma_irq_pkg::MAX_VECTORS,
  parameter int CNT_W = dma_irq_pkg::DESC_CNT_W,
  parameter int AW = dma_irq_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic user_rstn,
  input wire logic sys_rstn,
  input wire logic phy_ready,
  input wire logic [1:0] reset_source_sel,
  input wire logic [1:0] irq_mode,
  input wire logic [1:0] legacy_line_sel,
  input wire logic [dma_irq_pkg::VEC_W-1:0] chan_vector,
  input wire logic [dma_irq_pkg::VEC_W-1:0] user_vector,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] eng_irq_enable_mask,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] eng_run,
  input wire logic [dma_irq_pkg::NUM_ENG*AW-1:0] desc_start_addr,
  input wire logic [dma_irq_pkg::NUM_ENG*CNT_W-1:0] desc_adjacent,
  output logic [dma_irq_pkg::NUM_ENG-1:0] desc_fetch_req,
  output logic [dma_irq_pkg::NUM_ENG*AW-1:0] desc_fetch_addr,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] desc_fetch_ack,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] desc_fetch_err,
  output logic [dma_irq_pkg::NUM_ENG-1:0] data_move_req,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] data_move_done,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] data_move_err,
  output logic [dma_irq_pkg::NUM_ENG-1:0] eng_busy,
  output logic [dma_irq_pkg::NUM_ENG*2-1:0] eng_err_code,
  output logic [dma_irq_pkg::NUM_ENG*CNT_W-1:0] eng_desc_completed,
  output logic [dma_irq_pkg::NUM_ENG-1:0] chan_irq_pending,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] chan_irq_clear,
  input wire logic [NUM_USR-1:0] usr_irq_req,
  output logic [NUM_USR-1:0] usr_irq_ack,
  output logic legacy_assert,
  output logic [1:0] legacy_line,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [dma_irq_pkg::VEC_W-1:0] msg_vector,
  output logic dma_rstn_out
);
  if (MSI_VECTORS < 1 || MSI_VECTORS > dma_irq_pkg::MAX_VECTORS) begin
    $error("MSI_VECTORS out of range");
  end
  if (NUM_USR < 1 || NUM_USR + dma_irq_pkg::NUM_ENG > dma_irq_pkg::MAX_VECTORS) begin
    $error("NUM_USR out of range");
  end

  localparam int NE = dma_irq_pkg::NUM_ENG;
  localparam int VW = dma_irq_pkg::VEC_W;

  // reset source selection
  logic sel_rst;
  always_comb begin
    unique case (reset_source_sel)
      dma_irq_pkg::RST_SRC_SYS: sel_rst = sys_rstn;
      dma_irq_pkg::RST_SRC_PHY: sel_rst = phy_ready;
      default: sel_rst = user_rstn;
    endcase
  end

  // phy ready releases once; a later link drop does not reset the engines
  logic phy_src;
  logic phy_seen_q;
  logic rst_sync1_q;
  logic rst_sync2_q;
  assign phy_src = (reset_source_sel == dma_irq_pkg::RST_SRC_PHY);
  // forgotten when another source is chosen, so that source resets again
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phy_seen_q <= 1'b0;
    end else begin
      phy_seen_q <= phy_src && (phy_seen_q || phy_ready);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= sel_rst | (phy_src && phy_seen_q);
      rst_sync2_q <= rst_sync1_q;
    end
  end

  logic dma_rstn;
  assign dma_rstn = rst_sync2_q;
  assign dma_rstn_out = dma_rstn;

  // engines
  logic [NE-1:0] eng_done;
  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_eng
      dma_engine_seq #(.CNT_W(CNT_W), .AW(AW)) u_eng (
        .core_clk(core_clk),
        .dma_rstn(dma_rstn),
        .run(eng_run[g]),
        .desc_start_addr(desc_start_addr[g*AW +: AW]),
        .desc_adjacent(desc_adjacent[g*CNT_W +: CNT_W]),
        .desc_fetch_req(desc_fetch_req[g]),
        .desc_fetch_addr(desc_fetch_addr[g*AW +: AW]),
        .desc_fetch_ack(desc_fetch_ack[g]),
        .desc_fetch_err(desc_fetch_err[g]),
        .data_move_req(data_move_req[g]),
        .data_move_done(data_move_done[g]),
        .data_move_err(data_move_err[g]),
        .busy(eng_busy[g]),
        .done_pulse(eng_done[g]),
        .err_code(eng_err_code[g*2 +: 2]),
        .desc_completed(eng_desc_completed[g*CNT_W +: CNT_W])
      );
    end
  endgenerate

  // sticky per-engine pending, set wins over clear
  logic [NE-1:0] chan_pend_q;
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      chan_pend_q <= '0;
    end else begin
      chan_pend_q <= (chan_pend_q & ~chan_irq_clear) | eng_done;
    end
  end
  assign chan_irq_pending = chan_pend_q;

  // mask gates the channel interrupt
  logic [NE-1:0] chan_active;
  assign chan_active = chan_pend_q & eng_irq_enable_mask;

  // new user requests: rising edge of each request line
  logic [NUM_USR-1:0] usr_prev_q;
  logic [NUM_USR-1:0] usr_pend_q;
  logic [NE-1:0] chan_sent_q;
  logic [NUM_USR-1:0] usr_issue;
  logic [NE-1:0] chan_issue;

  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      usr_prev_q <= '0;
    end else begin
      usr_prev_q <= usr_irq_req;
    end
  end

  // pending user request, new edge wins over issue; drops if line falls
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      usr_pend_q <= '0;
    end else begin
      usr_pend_q <= ((usr_pend_q & ~usr_issue) | (usr_irq_req & ~usr_prev_q)) & usr_irq_req;
    end
  end

  // one message per channel completion
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      chan_sent_q <= '0;
    end else begin
      chan_sent_q <= (chan_sent_q | chan_issue) & chan_pend_q & ~eng_done;
    end
  end

  // first-set-bit picker, used for both source groups
  function automatic logic [31:0] first_bit(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 32'h0000_0000 | (32'h0000_0001 << i);
      end
    end
    return r;
  endfunction

  function automatic logic [VW-1:0] bit_index(input logic [31:0] v);
    logic [VW-1:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = VW'(i);
      end
    end
    return r;
  endfunction

  logic [NE-1:0] chan_want;
  logic [31:0] chan_pick;
  logic [31:0] usr_pick;
  logic is_msix;
  logic is_legacy;
  logic fire;
  assign is_msix = (irq_mode == dma_irq_pkg::MODE_MSIX);
  assign is_legacy = (irq_mode == dma_irq_pkg::MODE_LEGACY);
  assign chan_want = chan_active & ~chan_sent_q;
  assign chan_pick = first_bit(32'(chan_want));
  assign usr_pick = (chan_want != '0) ? 32'h0000_0000 : first_bit(32'(usr_pend_q));
  // legacy issues immediately; messages wait for ready
  assign fire = is_legacy || (msg_valid && msg_ready);
  assign chan_issue = fire ? NE'(chan_pick) : '0;
  assign usr_issue = fire ? NUM_USR'(usr_pick) : '0;

  // message vector: msi shares programmed vectors, msi-x one entry per source
  logic [VW-1:0] vec_d;
  logic [VW-1:0] vec_q;
  logic want_any;
  logic want_q;
  always_comb begin
    if (is_msix) begin
      vec_d = (chan_want != '0) ? bit_index(chan_pick)
        : VW'(bit_index(usr_pick) + VW'(NE));
    end else if (chan_want != '0) begin
      vec_d = chan_vector;
    end else begin
      vec_d = user_vector;
    end
    if (!is_msix && vec_d >= VW'(MSI_VECTORS - 1)) begin
      vec_d = VW'(MSI_VECTORS - 1);
    end
  end

  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d;
    end
  end
  assign msg_vector = vec_q;
  // offer only once the vector flop holds the current selection
  assign want_any = (chan_want != '0) || (usr_pend_q != '0);
  assign msg_valid = !is_legacy && want_any && want_q && (vec_q == vec_d);

  // one-cycle ack after the request is issued
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      usr_irq_ack <= '0;
    end else begin
      usr_irq_ack <= usr_issue;
    end
  end

  // legacy level follows any active source; line code A=0..D=3
  always_ff @(posedge core_clk or negedge dma_rstn) begin
    if (!dma_rstn) begin
      legacy_assert <= 1'b0;
      legacy_line <= dma_irq_pkg::LEG_LINE_A;
      want_q <= 1'b0;
    end else begin
      legacy_assert <= is_legacy && ((chan_active != '0) || (usr_irq_req != '0));
      legacy_line <= legacy_line_sel;
      want_q <= want_any;
    end
  end
endmodule

// >>> dma_irq_checker.sv
// concurrent checks on the ports of the dma interrupt request logic
`timescale 1ns/1ps
module dma_irq_checker #(
  parameter int NUM_USR = 16,
  parameter int MSI_VECTORS = 32
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic user_rstn,
  input wire logic [1:0] reset_source_sel,
  input wire logic [1:0] irq_mode,
  input wire logic [1:0] legacy_line_sel,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] eng_irq_enable_mask,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] eng_run,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] desc_fetch_req,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] chan_irq_pending,
  input wire logic [dma_irq_pkg::NUM_ENG-1:0] chan_irq_clear,
  input wire logic [NUM_USR-1:0] usr_irq_req,
  input wire logic [NUM_USR-1:0] usr_irq_ack,
  input wire logic legacy_assert,
  input wire logic [1:0] legacy_line,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [dma_irq_pkg::VEC_W-1:0] msg_vector,
  input wire logic dma_rstn_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic leg;
  logic hs;
  assign leg = (irq_mode == dma_irq_pkg::MODE_LEGACY);
  assign hs = msg_valid && msg_ready;
  a_line_follows: assert property (dma_rstn_out && leg && $stable(legacy_line_sel)
    |=> legacy_line == $past(legacy_line_sel)) else $error("legacy line code wrong");
  a_ack_pulse: assert property ((usr_irq_ack & $past(usr_irq_ack)) == '0)
    else $error("user ack longer than one cycle");
  a_ack_cause: assert property ((usr_irq_ack & ~$past(usr_irq_req)) == '0)
    else $error("user ack without request");
  a_ack_legacy: assert property ($rose(usr_irq_req[0]) && leg |-> ##[1:8] usr_irq_ack[0])
    else $error("legacy user request not acknowledged");
  a_msi_clamp: assert property (hs && irq_mode == dma_irq_pkg::MODE_MSI
    |-> msg_vector <= MSI_VECTORS - 1) else $error("msi vector beyond count");
  a_msix_range: assert property (hs && irq_mode == dma_irq_pkg::MODE_MSIX
    |-> msg_vector < NUM_USR + 2) else $error("msix vector outside table");
  a_pend_sticky: assert property (!dma_rstn_out
    || ($past(chan_irq_pending) & ~$past(chan_irq_clear) & ~chan_irq_pending) == '0)
    else $error("pending dropped without clear");
  a_mask_on: assert property ((leg && (chan_irq_pending & eng_irq_enable_mask) != '0)[*2]
    |-> legacy_assert) else $error("enabled channel not asserted");
  a_mask_off: assert property ((leg && (chan_irq_pending & eng_irq_enable_mask) == '0
    && usr_irq_req == '0)[*2] |-> !legacy_assert) else $error("masked channel asserted");
  a_fetch_start: assert property ($rose(eng_run[0]) && dma_rstn_out
    |-> ##[1:2] desc_fetch_req[0]) else $error("run did not start fetch");
  a_rst_user: assert property ((reset_source_sel == dma_irq_pkg::RST_SRC_USER
    && !user_rstn)[*3] |-> !dma_rstn_out) else $error("user reset not applied");
  a_rst_phy: assert property (reset_source_sel == dma_irq_pkg::RST_SRC_PHY
    && $past(reset_source_sel) == dma_irq_pkg::RST_SRC_PHY && $past(dma_rstn_out)
    |-> dma_rstn_out) else $error("phy mode reset reasserted");
  c_ack: cover property (usr_irq_ack != '0);
  c_pend: cover property ($rose(chan_irq_pending[0]));
  c_msix: cover property (hs && irq_mode == dma_irq_pkg::MODE_MSIX);
endmodule
bind dma_irq_request_logic dma_irq_checker #(.NUM_USR(NUM_USR), .MSI_VECTORS(MSI_VECTORS)) u_chk (
  .core_clk, .rstn, .user_rstn, .reset_source_sel, .irq_mode, .legacy_line_sel,
  .eng_irq_enable_mask, .eng_run, .desc_fetch_req, .chan_irq_pending, .chan_irq_clear,
  .usr_irq_req, .usr_irq_ack, .legacy_assert, .legacy_line, .msg_valid, .msg_ready,
  .msg_vector, .dma_rstn_out);

// >>> host_side_model.sv
// host memory and root complex model answering fetches, moves and messages
`timescale 1ns/1ps
module host_side_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [1:0] fetch_err_inj,
  input wire logic [1:0] move_err_inj,
  input wire logic [1:0] desc_fetch_req,
  input wire logic [1:0] data_move_req,
  input wire logic msg_valid,
  output logic [1:0] desc_fetch_ack,
  output logic [1:0] desc_fetch_err,
  output logic [1:0] data_move_done,
  output logic [1:0] data_move_err,
  output logic msg_ready
);
  int wf [2];
  int wm [2];
  // one answer pulse per request, random latency when slow
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      desc_fetch_ack <= '0;
      desc_fetch_err <= '0;
      data_move_done <= '0;
      data_move_err <= '0;
      msg_ready <= 1'b0;
      wf <= '{0, 0};
      wm <= '{0, 0};
    end else begin
      msg_ready <= msg_valid && (!slow || $urandom_range(1) == 1);
      for (int e = 0; e < 2; e++) begin
        desc_fetch_ack[e] <= 1'b0;
        desc_fetch_err[e] <= 1'b0;
        data_move_done[e] <= 1'b0;
        data_move_err[e] <= 1'b0;
        if (desc_fetch_req[e] && !desc_fetch_ack[e] && !desc_fetch_err[e]) begin
          wf[e] <= (wf[e] > 0) ? wf[e] - 1 : (slow ? $urandom_range(3) : 0);
          desc_fetch_ack[e] <= (wf[e] == 0) && !fetch_err_inj[e];
          desc_fetch_err[e] <= (wf[e] == 0) && fetch_err_inj[e];
        end
        if (data_move_req[e] && !data_move_done[e] && !data_move_err[e]) begin
          wm[e] <= (wm[e] > 0) ? wm[e] - 1 : (slow ? $urandom_range(3) : 0);
          data_move_done[e] <= (wm[e] == 0) && !move_err_inj[e];
          data_move_err[e] <= (wm[e] == 0) && move_err_inj[e];
        end
      end
    end
  end
endmodule

// >>> dma_irq_request_logic_tb_top.sv
// self-checking bench for the dma interrupt request logic
`timescale 1ns/1ps
module dma_irq_request_logic_tb_top;
  localparam int MSIV = 4;
  logic core_clk, rstn, user_rstn, sys_rstn, phy_ready, slow, legacy_assert, msg_valid;
  logic msg_ready, dma_rstn_out;
  logic [1:0] reset_source_sel, irq_mode, legacy_line_sel, eng_irq_enable_mask, eng_run;
  logic [1:0] chan_irq_clear, fetch_err_inj, move_err_inj, legacy_line, eng_busy;
  logic [1:0] desc_fetch_req, desc_fetch_ack, desc_fetch_err, chan_irq_pending;
  logic [1:0] data_move_req, data_move_done, data_move_err;
  logic [4:0] chan_vector, user_vector, msg_vector;
  logic [127:0] desc_start_addr, desc_fetch_addr;
  logic [31:0] desc_adjacent, eng_desc_completed;
  logic [3:0] eng_err_code;
  logic [15:0] usr_irq_req, usr_irq_ack;
  logic [63:0] addr_q [2][$];
  int error_cnt, checked, i, v;
  dma_irq_request_logic #(.MSI_VECTORS(MSIV)) dut (.*);
  host_side_model u_host (.*);
  always #4 core_clk = ~core_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      chk(n, 0);
      stop_test();
    end
  endtask
  always @(negedge core_clk) begin
    for (int e = 0; e < 2; e++) begin
      if (desc_fetch_req[e] && desc_fetch_ack[e])
        chk(desc_fetch_addr[e*64 +: 64], addr_q[e].size() ? addr_q[e].pop_front() : '1);
    end
  end
  task automatic run_eng(input int e, input int n, input logic [1:0] err);
    logic [63:0] a;
    a = {$urandom(), $urandom() & 32'hffff_ffe0};
    for (int k = 0; k <= n; k++) addr_q[e].push_back(a + 64'(dma_irq_pkg::DESC_STRIDE * k));
    @(posedge core_clk);
    desc_start_addr[e*64 +: 64] <= a;
    desc_adjacent[e*16 +: 16] <= 16'(n);
    fetch_err_inj[e] <= err[0];
    move_err_inj[e] <= err[1];
    @(posedge core_clk);
    eng_run[e] <= 1'b1;
    if (err == 2'h0) begin
      for (i = 0; i < 300 && chan_irq_pending[e] !== 1'b1; i++) @(negedge core_clk);
      tmo(i);
      chk(eng_desc_completed[e*16 +: 16], n + 1);
      chk(eng_err_code[e*2 +: 2], dma_irq_pkg::ERR_NONE);
      chk(addr_q[e].size(), 0);
      repeat (3) @(negedge core_clk);
      chk(legacy_assert, 1'b0);
      chk(msg_valid, 1'b0);
      @(posedge core_clk);
      eng_irq_enable_mask[e] <= 1'b1;
      for (i = 0; i < 300 && irq_mode != dma_irq_pkg::MODE_LEGACY
           && (msg_valid & msg_ready) !== 1'b1; i++) @(negedge core_clk);
      tmo(i);
      if (irq_mode == dma_irq_pkg::MODE_MSIX) chk(msg_vector, e);
      repeat (3) @(negedge core_clk);
      chk(legacy_assert, irq_mode == dma_irq_pkg::MODE_LEGACY);
      chk(msg_valid, 1'b0);
      @(posedge core_clk);
      eng_irq_enable_mask[e] <= 1'b0;
    end else begin
      for (i = 0; i < 300 && eng_err_code[e*2 +: 2] === 2'h0; i++) @(negedge core_clk);
      tmo(i);
      chk(eng_err_code[e*2 +: 2], err[0] ? dma_irq_pkg::ERR_FETCH : dma_irq_pkg::ERR_DATA);
      addr_q[e].delete();
    end
    @(posedge core_clk);
    eng_run[e] <= 1'b0;
    for (i = 0; i < 300 && eng_busy[e] !== 1'b0; i++) @(negedge core_clk);
    tmo(i);
    repeat (3) @(posedge core_clk);
    chan_irq_clear[e] <= 1'b1;
    @(posedge core_clk);
    chan_irq_clear[e] <= 1'b0;
    @(negedge core_clk);
    chk(chan_irq_pending[e], 1'b0);
    @(posedge core_clk);
  endtask
  task automatic usr(input int b, input logic [4:0] ev);
    @(posedge core_clk);
    usr_irq_req[b] <= 1'b1;
    if (irq_mode != dma_irq_pkg::MODE_LEGACY) begin
      for (i = 0; i < 300 && (msg_valid & msg_ready) !== 1'b1; i++) @(negedge core_clk);
      tmo(i);
      chk(msg_vector, ev);
    end
    for (i = 0; i < 300 && usr_irq_ack[b] !== 1'b1; i++) @(negedge core_clk);
    tmo(i);
    if (irq_mode == dma_irq_pkg::MODE_MSIX) begin
      @(posedge core_clk);
      usr_irq_req[b] <= 1'b0;
    end else begin
      chk(legacy_assert, irq_mode == dma_irq_pkg::MODE_LEGACY);
      if (irq_mode == dma_irq_pkg::MODE_LEGACY) chk(legacy_line, ev[1:0]);
    end
    @(negedge core_clk);
    chk(usr_irq_ack[b], 1'b0);
    repeat (3) @(posedge core_clk);
    usr_irq_req[b] <= 1'b0;
  endtask
  initial begin
    {core_clk, rstn, slow, reset_source_sel, irq_mode, legacy_line_sel} = '0;
    {eng_irq_enable_mask, eng_run, chan_irq_clear, fetch_err_inj, move_err_inj} = '0;
    {chan_vector, user_vector, desc_start_addr, desc_adjacent, usr_irq_req} = '0;
    {user_rstn, sys_rstn, phy_ready} = 3'h7;
    {error_cnt, checked} = '0;
    void'($urandom(32'hcae8_50b0));
    repeat (5) @(negedge core_clk);
    chk({usr_irq_ack, msg_valid, legacy_assert, chan_irq_pending, dma_rstn_out}, 0);
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      run_eng(k / 2, $urandom_range(3), 2'h0);
    end
    run_eng(0, 2, 2'h1);
    run_eng(1, 1, 2'h2);
    for (int l = 0; l < 4; l++) begin
      @(posedge core_clk);
      legacy_line_sel <= 2'(l);
      chan_vector <= 5'(l);
      user_vector <= 5'(l);
      usr(l, 5'(l));
    end
    @(posedge core_clk);
    irq_mode <= dma_irq_pkg::MODE_MSI;
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = $urandom_range(31);
      @(posedge core_clk);
      user_vector <= 5'(v);
      usr($urandom_range(15), 5'((v > MSIV - 1) ? MSIV - 1 : v));
    end
    @(posedge core_clk);
    irq_mode <= dma_irq_pkg::MODE_MSIX;
    for (int k = 0; k < 4; k++) begin
      v = $urandom_range(15);
      usr(v, 5'(v + 2));
    end
    run_eng(1, 1, 2'h0);
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      reset_source_sel <= 2'(s);
      user_rstn <= !s[0];
      sys_rstn <= s[0];
      repeat (4) @(negedge core_clk);
      chk(dma_rstn_out, 1'b1);
      @(posedge core_clk);
      {user_rstn, sys_rstn} <= 2'h0;
      repeat (4) @(negedge core_clk);
      chk(dma_rstn_out, 1'b0);
      @(posedge core_clk);
      {user_rstn, sys_rstn} <= 2'h3;
      repeat (4) @(negedge core_clk);
      chk(dma_rstn_out, 1'b1);
    end
    @(posedge core_clk);
    reset_source_sel <= dma_irq_pkg::RST_SRC_PHY;
    repeat (4) @(posedge core_clk);
    phy_ready <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk(dma_rstn_out, 1'b1);
    stop_test();
  end
endmodule
